/* src/fmb_mailbox_fifo.sv */
// Port A to port B FIFO with fall-through output, retransmit and two mailboxes
// Notes on behaviour
// - In-order 36-bit FIFO, 512 to 2048 deep
// - Oldest word falls through to output register
// - Retransmit replays words from a marked word
// - Two mailboxes, each with a new-mail flag
// - Transfers only on enabled port clock rise
// - Port clocks independent, may be coincident
// - Input flags advance on port A clock
// - Output flags advance on port B clock
// - Offsets loaded from port A or serially
// - Near-empty low when count at most offset
// - Near-full low when free at most offset
// - Port A select gates transfers and drivers
// - Port B select gates transfers and drivers
// - Port A direction: high write, low read
// - Output ready rises third B edge; low in reset
`timescale 1ns/1ps
module fmb_mailbox_fifo
    import fmb_pkg::*;
#(
    parameter int DEPTH = DEPTH_DEF
) (
    // System
    input  wire logic              REF_CLK,
    input  wire logic              RST_B,
    // Port A pins
    input  wire logic              PORT_A_CLOCK,
    input  wire logic              PORT_A_SELECT_N,
    input  wire logic              PORT_A_GATE,
    input  wire logic              PORT_A_DIR,
    input  wire logic              PORT_A_MAIL_SEL,
    input  wire logic              OFS_MODE1_SER_EN_N,
    input  wire logic              OFS_MODE0_SER_DATA,
    input  wire logic [DATA_W-1:0] PORT_A_BUS_I,
    output logic      [DATA_W-1:0] PORT_A_BUS_O,
    output logic                   PORT_A_BUS_OE,
    // Port A flags
    output logic                   WRITE_SPACE_FLAG,
    output logic                   NEAR_FULL_FLAG_N,
    output logic                   MAIL2_FULL_N,
    // Port B pins
    input  wire logic              PORT_B_CLOCK,
    input  wire logic              PORT_B_SELECT_N,
    input  wire logic              PORT_B_GATE,
    input  wire logic              PORT_B_DIR,
    input  wire logic              PORT_B_MAIL_SEL,
    input  wire logic              RETX_MODE,
    input  wire logic              RETX_FROM_MARK,
    input  wire logic [DATA_W-1:0] PORT_B_BUS_I,
    output logic      [DATA_W-1:0] PORT_B_BUS_O,
    output logic                   PORT_B_BUS_OE,
    // Port B flags
    output logic                   READ_READY_FLAG,
    output logic                   NEAR_EMPTY_FLAG_N,
    output logic                   MAIL1_FULL_N
);
    localparam int AW  = $clog2(DEPTH);
    localparam int PW  = AW + 1;
    localparam int SBITS = 2 * AW;
    localparam int SCW = $clog2(SBITS + 1);
    localparam logic [PW-1:0]  DEPTH_P = PW'(DEPTH);
    localparam logic [SCW-1:0] SER_LAST = SCW'(SBITS - 1);

    typedef struct packed {
        logic [1:0]        boot_cnt;
        logic              booted;
        fmb_ofs_mode_t     ofs_mode;
        logic              ofs_ready;
        logic              par_step;
        logic [SCW-1:0]    ser_cnt;
        logic [AW-1:0]     ofs_x;
        logic [AW-1:0]     ofs_y;
        logic [PW-1:0]     wr_ptr;
        logic [PW-1:0]     rd_ptr;
        logic [PW-1:0]     mark_ptr;
        logic [PW-1:0]     b_wr1;
        logic [PW-1:0]     b_wr2;
        logic [PW-1:0]     a_rd1;
        logic [PW-1:0]     a_rd2;
        logic              rt_mode;
        logic [DATA_W-1:0] fifo_out;
        logic [DATA_W-1:0] mail1;
        logic [DATA_W-1:0] mail2;
        logic [DATA_W-1:0] b_bus;
        logic              out_ready;
        logic              write_space;
        logic              near_full_n;
        logic              near_empty_n;
        logic              mail1_full_n;
        logic              mail2_full_n;
        logic              a_oe;
        logic              b_oe;
    } fmb_state_t;

    fmb_state_t st_reg;
    fmb_state_t st_next;

    logic [DATA_W-1:0] mem [DEPTH];
    logic              mem_we;
    logic [AW-1:0]     mem_rd_addr;
    logic [DATA_W-1:0] mem_rd_data;

    fmb_port_if pa ();
    fmb_port_if pb ();

    // Port clocks are sampled, so REF_CLK must run well above either of them
    fmb_pin_sync u_sync_a (
        .clk      (REF_CLK),
        .rst_b    (RST_B),
        .pin_clk  (PORT_A_CLOCK),
        .pin_ctl  ({PORT_A_SELECT_N, PORT_A_GATE, PORT_A_DIR, PORT_A_MAIL_SEL,
                    OFS_MODE1_SER_EN_N, OFS_MODE0_SER_DATA}),
        .pin_data (PORT_A_BUS_I),
        .port     (pa.src)
    );

    fmb_pin_sync u_sync_b (
        .clk      (REF_CLK),
        .rst_b    (RST_B),
        .pin_clk  (PORT_B_CLOCK),
        .pin_ctl  ({PORT_B_SELECT_N, PORT_B_GATE, PORT_B_DIR, PORT_B_MAIL_SEL,
                    RETX_MODE, RETX_FROM_MARK}),
        .pin_data (PORT_B_BUS_I),
        .port     (pb.src)
    );

    logic a_act;
    logic b_act;
    logic b_rfm;
    logic b_pop;
    logic b_mw;
    logic [PW-1:0] a_used;
    logic [PW-1:0] b_count;

    // Transfers need select low and gate high on a port clock rise
    assign a_act = pa.clk_rise & ~pa.ctl[CTL_SEL_N] & pa.ctl[CTL_GATE];
    assign b_act = pb.clk_rise & ~pb.ctl[CTL_SEL_N] & pb.ctl[CTL_GATE];
    assign b_rfm = st_reg.rt_mode & pb.ctl[CTL_AUX0];
    assign b_pop = b_act & ~pb.ctl[CTL_DIR] & ~pb.ctl[CTL_MAIL] & st_reg.out_ready;
    assign b_mw  = b_act & pb.ctl[CTL_DIR] & pb.ctl[CTL_MAIL];
    assign mem_rd_addr = b_rfm ? st_reg.mark_ptr[AW-1:0] : st_reg.rd_ptr[AW-1:0];
    assign mem_rd_data = mem[mem_rd_addr];

    always_comb begin
        st_next = st_reg;
        mem_we  = 1'b0;
        a_used  = '0;
        b_count = '0;

        // Straps read once the synchronisers hold settled pin levels
        if (!st_reg.booted) begin
            st_next.boot_cnt = st_reg.boot_cnt + 2'h1;
            if (st_reg.boot_cnt == BOOT_LAST) begin
                st_next.booted   = 1'b1;
                st_next.ofs_mode = fmb_ofs_mode_t'(pa.ctl[CTL_AUX1:CTL_AUX0]);
                unique case (st_next.ofs_mode)
                    OFS_PRESET_LO: begin
                        st_next.ofs_x     = AW'(PRESET_LO);
                        st_next.ofs_y     = AW'(PRESET_LO);
                        st_next.ofs_ready = 1'b1;
                    end
                    OFS_PRESET_HI: begin
                        st_next.ofs_x     = AW'(PRESET_HI);
                        st_next.ofs_y     = AW'(PRESET_HI);
                        st_next.ofs_ready = 1'b1;
                    end
                    OFS_PARALLEL, OFS_SERIAL: begin
                        st_next.ofs_ready = 1'b0;
                    end
                endcase
            end
        end

        // Port B first, so a port A mail store in the same cycle wins
        if (pb.clk_rise && st_reg.booted) begin
            st_next.b_wr1 = st_reg.wr_ptr;
            st_next.b_wr2 = st_reg.b_wr1;
            if (b_act && pb.ctl[CTL_DIR] && pb.ctl[CTL_MAIL]) begin
                st_next.mail2        = pb.data;
                st_next.mail2_full_n = 1'b0;
            end
            if (b_act && !pb.ctl[CTL_DIR] && pb.ctl[CTL_MAIL]) begin
                st_next.mail1_full_n = 1'b1;
            end
            if (pb.ctl[CTL_AUX1]) begin
                if (!st_reg.rt_mode && st_reg.out_ready) begin
                    st_next.rt_mode  = 1'b1;
                    st_next.mark_ptr = st_reg.rd_ptr - PW'(1);
                end
            end else begin
                st_next.rt_mode = 1'b0;
            end
            if (b_rfm) begin
                st_next.fifo_out  = mem_rd_data;
                st_next.rd_ptr    = st_reg.mark_ptr + PW'(1);
                st_next.out_ready = 1'b1;
            end else if (b_pop || !st_reg.out_ready) begin
                // Word visible only after two B edges, loaded on the third
                if (st_reg.b_wr2 != st_reg.rd_ptr) begin
                    st_next.fifo_out  = mem_rd_data;
                    st_next.rd_ptr    = st_reg.rd_ptr + PW'(1);
                    st_next.out_ready = 1'b1;
                end else begin
                    st_next.out_ready = 1'b0;
                end
            end
            b_count = st_next.b_wr2 - st_next.rd_ptr + PW'(st_next.out_ready);
            st_next.near_empty_n = b_count > {1'b0, st_next.ofs_x};
        end

        if (pa.clk_rise && st_reg.booted) begin
            // Marked words stay protected while retransmit is armed
            // Word in the output register still occupies a slot
            st_next.a_rd1 = st_reg.rt_mode ? st_reg.mark_ptr
                                           : st_reg.rd_ptr - PW'(st_reg.out_ready);
            st_next.a_rd2 = st_reg.a_rd1;
            if (st_reg.ofs_mode == OFS_SERIAL && !st_reg.ofs_ready
                    && !pa.ctl[CTL_AUX1]) begin
                {st_next.ofs_y, st_next.ofs_x} = {st_reg.ofs_y[AW-2:0], st_reg.ofs_x,
                                                  pa.ctl[CTL_AUX0]};
                st_next.ser_cnt = st_reg.ser_cnt + SCW'(1);
                if (st_reg.ser_cnt == SER_LAST) begin
                    st_next.ofs_ready = 1'b1;
                end
            end
            if (a_act && pa.ctl[CTL_DIR]) begin
                if (pa.ctl[CTL_MAIL]) begin
                    st_next.mail1        = pa.data;
                    st_next.mail1_full_n = 1'b0;
                end else if (st_reg.ofs_mode == OFS_PARALLEL && !st_reg.ofs_ready) begin
                    if (!st_reg.par_step) begin
                        st_next.ofs_x    = pa.data[AW-1:0];
                        st_next.par_step = 1'b1;
                    end else begin
                        st_next.ofs_y     = pa.data[AW-1:0];
                        st_next.ofs_ready = 1'b1;
                    end
                end else if (st_reg.write_space) begin
                    mem_we         = 1'b1;
                    st_next.wr_ptr = st_reg.wr_ptr + PW'(1);
                end
            end
            // A same-cycle mail store from port B keeps the flag set
            if (a_act && !pa.ctl[CTL_DIR] && pa.ctl[CTL_MAIL] && !b_mw) begin
                st_next.mail2_full_n = 1'b1;
            end
            a_used = st_next.wr_ptr - st_next.a_rd2;
            st_next.write_space = st_next.ofs_ready && (a_used < DEPTH_P);
            st_next.near_full_n = (DEPTH_P - a_used) > {1'b0, st_next.ofs_y};
        end

        // Drivers stay off unless selected and reading
        // Synchronisers reset to all zeros, which would read as a selected read
        st_next.a_oe  = st_reg.booted & ~pa.ctl[CTL_SEL_N] & ~pa.ctl[CTL_DIR];
        st_next.b_oe  = st_reg.booted & ~pb.ctl[CTL_SEL_N] & ~pb.ctl[CTL_DIR];
        st_next.b_bus = pb.ctl[CTL_MAIL] ? st_next.mail1 : st_next.fifo_out;
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            st_reg              <= '0;
            st_reg.near_full_n  <= 1'b1;
            st_reg.mail1_full_n <= 1'b1;
            st_reg.mail2_full_n <= 1'b1;
            st_reg.mail1        <= MAIL_RST;
            st_reg.mail2        <= MAIL_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // Storage kept out of the reset state so it maps to RAM
    always_ff @(posedge REF_CLK) begin
        if (mem_we) begin
            mem[st_reg.wr_ptr[AW-1:0]] <= pa.data;
        end
    end

    assign PORT_A_BUS_O      = st_reg.mail2;
    assign PORT_A_BUS_OE     = st_reg.a_oe;
    assign WRITE_SPACE_FLAG  = st_reg.write_space;
    assign NEAR_FULL_FLAG_N  = st_reg.near_full_n;
    assign MAIL2_FULL_N      = st_reg.mail2_full_n;
    assign PORT_B_BUS_O      = st_reg.b_bus;
    assign PORT_B_BUS_OE     = st_reg.b_oe;
    assign READ_READY_FLAG   = st_reg.out_ready;
    assign NEAR_EMPTY_FLAG_N = st_reg.near_empty_n;
    assign MAIL1_FULL_N      = st_reg.mail1_full_n;
endmodule

/* src/fmb_pkg.sv */
// Shared constants and types for the dual-port FIFO with mailboxes
package fmb_pkg;
    localparam int DATA_W      = 36;
    localparam int DEPTH_DEF   = 512;
    localparam int CTL_W       = 6;
    // Control vector positions, common to both ports
    localparam int CTL_SEL_N   = 5;
    localparam int CTL_GATE    = 4;
    localparam int CTL_DIR     = 3;
    localparam int CTL_MAIL    = 2;
    localparam int CTL_AUX1    = 1;
    localparam int CTL_AUX0    = 0;
    // Reference cycles after reset release before straps are read
    localparam logic [1:0] BOOT_LAST   = 2'h3;
    // Preset offsets for the two automatic modes (arbitrary defaults)
    localparam int PRESET_LO   = 8;
    localparam int PRESET_HI   = 16;
    localparam logic [DATA_W-1:0] MAIL_RST = 36'h0_0000_0000;

    typedef enum logic [1:0] {
        OFS_PARALLEL,
        OFS_SERIAL,
        OFS_PRESET_LO,
        OFS_PRESET_HI
    } fmb_ofs_mode_t;
endpackage

/* src/fmb_port_if.sv */
// Synchronised view of one port's pins, passed to the FIFO core
`timescale 1ns/1ps
interface fmb_port_if;
    import fmb_pkg::*;
    logic              clk_rise;
    logic [CTL_W-1:0]  ctl;
    logic [DATA_W-1:0] data;
    modport src (output clk_rise, output ctl, output data);
    modport dst (input clk_rise, input ctl, input data);
endinterface

/* src/fmb_pin_sync.sv */
// Two-flop synchroniser and port clock edge detector for one port
`timescale 1ns/1ps
module fmb_pin_sync
    import fmb_pkg::*;
(
    // System
    input  wire logic              clk,
    input  wire logic              rst_b,
    // Raw pins
    input  wire logic              pin_clk,
    input  wire logic [CTL_W-1:0]  pin_ctl,
    input  wire logic [DATA_W-1:0] pin_data,
    // Synchronised side
    fmb_port_if.src                port
);
    localparam int VW = 1 + CTL_W + DATA_W;

    typedef struct packed {
        logic [VW-1:0] s1;
        logic [VW-1:0] s2;
        logic          clk_prev;
    } fmb_sync_t;

    fmb_sync_t s_reg;
    fmb_sync_t s_next;

    // Clock travels with its data so both see the same delay
    always_comb begin
        s_next          = s_reg;
        s_next.s1       = {pin_clk, pin_ctl, pin_data};
        s_next.s2       = s_reg.s1;
        s_next.clk_prev = s_reg.s2[VW-1];
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign port.clk_rise = s_reg.s2[VW-1] & ~s_reg.clk_prev;
    assign port.ctl      = s_reg.s2[VW-2 -: CTL_W];
    assign port.data     = s_reg.s2[DATA_W-1:0];
endmodule

/* verification/fmb_mailbox_fifo_monitor.sv */
// Port-level checker for the FIFO with mailboxes
`timescale 1ns/1ps
module fmb_mailbox_fifo_monitor
    import fmb_pkg::*;
#(
    parameter int DEPTH = DEPTH_DEF
) (
    // System
    input wire logic REF_CLK,
    input wire logic RST_B,
    // Port A
    input wire logic PORT_A_CLOCK,
    input wire logic PORT_A_SELECT_N,
    input wire logic PORT_A_GATE,
    input wire logic PORT_A_DIR,
    input wire logic PORT_A_MAIL_SEL,
    input wire logic PORT_A_BUS_OE,
    input wire logic WRITE_SPACE_FLAG,
    input wire logic NEAR_FULL_FLAG_N,
    // Port B
    input wire logic PORT_B_CLOCK,
    input wire logic PORT_B_SELECT_N,
    input wire logic PORT_B_GATE,
    input wire logic PORT_B_DIR,
    input wire logic PORT_B_MAIL_SEL,
    input wire logic PORT_B_BUS_OE,
    input wire logic READ_READY_FLAG,
    input wire logic NEAR_EMPTY_FLAG_N,
    input wire logic MAIL1_FULL_N
);
    // Short history of port edges, so flag moves can be tied to a cause
    logic [5:0] a_rise_reg;
    logic [5:0] b_rise_reg;
    logic [5:0] a_mw_reg;
    logic [5:0] b_mr_reg;
    logic       a_clk_reg;
    logic       b_clk_reg;
    wire        a_rise = PORT_A_CLOCK & ~a_clk_reg;
    wire        b_rise = PORT_B_CLOCK & ~b_clk_reg;

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            {a_rise_reg, b_rise_reg, a_mw_reg, b_mr_reg, a_clk_reg, b_clk_reg} <= '0;
        end else begin
            a_clk_reg  <= PORT_A_CLOCK;
            b_clk_reg  <= PORT_B_CLOCK;
            a_rise_reg <= {a_rise_reg[4:0], a_rise};
            b_rise_reg <= {b_rise_reg[4:0], b_rise};
            a_mw_reg   <= {a_mw_reg[4:0], a_rise & ~PORT_A_SELECT_N & PORT_A_GATE
                           & PORT_A_DIR & PORT_A_MAIL_SEL};
            b_mr_reg   <= {b_mr_reg[4:0], b_rise & ~PORT_B_SELECT_N & PORT_B_GATE
                           & ~PORT_B_DIR & PORT_B_MAIL_SEL};
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);

    property p_rst_flags;
        disable iff (1'b0) (!RST_B ##1 !RST_B) |-> !READ_READY_FLAG && !WRITE_SPACE_FLAG
            && MAIL1_FULL_N;
    endproperty
    property p_a_oe_off;
        (PORT_A_SELECT_N | PORT_A_DIR) [*4] |=> !PORT_A_BUS_OE;
    endproperty
    property p_a_oe_on;
        (!PORT_A_SELECT_N & !PORT_A_DIR) [*4] |=> PORT_A_BUS_OE;
    endproperty
    property p_b_oe_off;
        PORT_B_SELECT_N [*4] |=> !PORT_B_BUS_OE;
    endproperty
    property p_b_oe_on;
        (!PORT_B_SELECT_N & !PORT_B_DIR) [*4] |=> PORT_B_BUS_OE;
    endproperty
    property p_space_sync;
        $changed(WRITE_SPACE_FLAG) |-> |a_rise_reg[5:1];
    endproperty
    property p_full_sync;
        $changed(NEAR_FULL_FLAG_N) |-> |a_rise_reg[5:1];
    endproperty
    property p_ready_sync;
        $changed(READ_READY_FLAG) |-> |b_rise_reg[5:1];
    endproperty
    property p_empty_sync;
        $changed(NEAR_EMPTY_FLAG_N) |-> |b_rise_reg[5:1];
    endproperty
    property p_mail_set;
        $fell(MAIL1_FULL_N) |-> |a_mw_reg[5:1];
    endproperty
    property p_mail_clr;
        $rose(MAIL1_FULL_N) |-> |b_mr_reg[5:1];
    endproperty

    a_rst_flags: assert property (p_rst_flags)
        else $error("flags wrong while reset is held");
    a_a_oe_off: assert property (p_a_oe_off)
        else $error("port A bus driven while deselected or writing");
    a_a_oe_on: assert property (p_a_oe_on)
        else $error("port A bus not driven during selected read");
    a_b_oe_off: assert property (p_b_oe_off)
        else $error("port B bus driven while deselected");
    a_b_oe_on: assert property (p_b_oe_on)
        else $error("port B bus not driven during selected read");
    a_space_sync: assert property (p_space_sync)
        else $error("write space moved without a port A edge");
    a_full_sync: assert property (p_full_sync)
        else $error("near full moved without a port A edge");
    a_ready_sync: assert property (p_ready_sync)
        else $error("read ready moved without a port B edge");
    a_empty_sync: assert property (p_empty_sync)
        else $error("near empty moved without a port B edge");
    a_mail_set: assert property (p_mail_set)
        else $error("mail flag set without a port A mail write");
    a_mail_clr: assert property (p_mail_clr)
        else $error("mail flag cleared without a port B mail read");

    c_mail: cover property ($fell(MAIL1_FULL_N));
    c_ready: cover property ($rose(READ_READY_FLAG));
    c_full: cover property ($fell(WRITE_SPACE_FLAG));
endmodule

bind fmb_mailbox_fifo fmb_mailbox_fifo_monitor #(.DEPTH(DEPTH)) u_fmb_mailbox_fifo_monitor (.*);

/* verification/fmb_port_partner.sv */
// Free-running port clock of the far-side controller
`timescale 1ns/1ps
module fmb_port_partner #(
    parameter int HALF = 4
) (
    input  wire logic clk,
    output logic      port_clk
);
    int cnt = 0;
    initial port_clk = 1'b0;
    // Runs through reset too, since reset needs port edges
    // Each side picks its own period, unrelated to the other
    always @(posedge clk) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1) begin
            port_clk <= ~port_clk;
        end
    end
endmodule

/* verification/dual_clock_fifo_mailbox_bench.sv */
// Self-checking bench for the FIFO with mailboxes
`timescale 1ns/1ps
module dual_clock_fifo_mailbox_bench
    import fmb_pkg::*;
;
    localparam int DEPTH = DEPTH_DEF;
    logic REF_CLK = 1'b0;
    logic RST_B = 1'b0;
    // Controls packed as {select_n, gate, dir, mail_sel}
    logic [3:0] a_c = 4'h8;
    logic [3:0] b_c = 4'h8;
    logic ser_en_n = 1'b0;
    logic ser_d = 1'b0;
    logic rtm = 1'b0;
    logic rfm = 1'b0;
    logic [DATA_W-1:0] a_bus = '0;
    logic [DATA_W-1:0] b_bus = '0;
    logic [DATA_W-1:0] a_out, b_out, rd, d;
    logic [DATA_W-1:0] w[3];
    logic a_oe, b_oe, space, nfull_n, mb2_n, ready, nempty_n, mb1_n, a_clk, b_clk;
    logic [DATA_W-1:0] q[$];
    int xo = 3;
    int yo = 5;
    int error_cnt = 0;
    int checks_done = 0;

    initial forever #12.5 REF_CLK = ~REF_CLK;

    fmb_port_partner #(.HALF(4)) u_clk_a (.clk(REF_CLK), .port_clk(a_clk));
    fmb_port_partner #(.HALF(5)) u_clk_b (.clk(REF_CLK), .port_clk(b_clk));

    fmb_mailbox_fifo #(.DEPTH(DEPTH)) u_fmb_mailbox_fifo (
        .REF_CLK(REF_CLK), .RST_B(RST_B), .PORT_A_CLOCK(a_clk),
        .PORT_A_SELECT_N(a_c[3]), .PORT_A_GATE(a_c[2]), .PORT_A_DIR(a_c[1]),
        .PORT_A_MAIL_SEL(a_c[0]), .OFS_MODE1_SER_EN_N(ser_en_n), .OFS_MODE0_SER_DATA(ser_d),
        .PORT_A_BUS_I(a_bus), .PORT_A_BUS_O(a_out), .PORT_A_BUS_OE(a_oe),
        .WRITE_SPACE_FLAG(space), .NEAR_FULL_FLAG_N(nfull_n), .MAIL2_FULL_N(mb2_n),
        .PORT_B_CLOCK(b_clk), .PORT_B_SELECT_N(b_c[3]), .PORT_B_GATE(b_c[2]),
        .PORT_B_DIR(b_c[1]), .PORT_B_MAIL_SEL(b_c[0]), .RETX_MODE(rtm),
        .RETX_FROM_MARK(rfm), .PORT_B_BUS_I(b_bus), .PORT_B_BUS_O(b_out),
        .PORT_B_BUS_OE(b_oe), .READ_READY_FLAG(ready), .NEAR_EMPTY_FLAG_N(nempty_n),
        .MAIL1_FULL_N(mb1_n));

    function automatic logic pc(input bit b);
        return b ? b_clk : a_clk;
    endfunction
    function automatic logic [DATA_W-1:0] rnd();
        return DATA_W'({$urandom(), $urandom()});
    endfunction

    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkf(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    // Controls are set just after a falling port edge, so they are settled
    // for the whole low phase and dropped only once the rise was sampled
    task automatic op(input bit b, input logic [3:0] c, input logic [DATA_W-1:0] dv);
        do @(posedge REF_CLK); while (pc(b) !== 1'b1);
        do @(posedge REF_CLK); while (pc(b) !== 1'b0);
        if (b) begin
            b_c <= c;
            b_bus <= dv;
        end else begin
            a_c <= c;
            a_bus <= dv;
        end
        do @(posedge REF_CLK); while (pc(b) !== 1'b1);
        rd = b ? b_out : a_out;
        if (b) begin
            b_c <= 4'h8;
            b_bus <= ~dv;
        end else begin
            a_c <= 4'h8;
            a_bus <= ~dv;
        end
    endtask

    task automatic settle();
        repeat (60) @(posedge REF_CLK);
    endtask
    task automatic flags();
        chkf(ready, q.size() > 0);
        chkf(nempty_n, q.size() > xo);
        chkf(space, q.size() < DEPTH);
        chkf(nfull_n, (DEPTH - q.size()) > yo);
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge REF_CLK);
        error_cnt++;
        give_verdict();
    end

    initial begin
        void'($urandom(38));
        repeat (12) @(posedge b_clk);
        @(posedge REF_CLK);
        RST_B <= 1'b1;
        repeat (8) @(posedge REF_CLK);
        ser_en_n <= 1'b1;
        chkf(ready, 1'b0);
        op(0, 4'h6, DATA_W'(xo));
        op(0, 4'h6, DATA_W'(yo));
        settle();
        flags();
        // In-order fall-through traffic, then a read of an empty FIFO
        for (int i = 0; i < 6; i++) begin
            d = rnd();
            q.push_back(d);
            op(0, 4'h6, d);
        end
        op(0, 4'he, rnd());
        settle();
        flags();
        while (q.size() > 0) begin
            op(1, 4'h4, rnd());
            chk(rd, q.pop_front());
        end
        op(1, 4'h4, rnd());
        settle();
        flags();
        // Mailboxes in both directions
        d = rnd();
        op(0, 4'h7, d);
        settle();
        chkf(mb1_n, 1'b0);
        op(1, 4'h5, rnd());
        chk(rd, d);
        d = rnd();
        op(1, 4'h7, d);
        settle();
        chkf(mb1_n, 1'b1);
        chkf(mb2_n, 1'b0);
        op(0, 4'h5, rnd());
        chk(rd, d);
        settle();
        chkf(mb2_n, 1'b1);
        chkf(a_oe, 1'b0);
        flags();
        // Retransmit from the first of three words
        for (int i = 0; i < 3; i++) begin
            w[i] = rnd();
            op(0, 4'h6, w[i]);
        end
        settle();
        rtm <= 1'b1;
        settle();
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 3; i++) begin
                op(1, 4'h4, rnd());
                chk(rd, w[i]);
            end
            // Rewind once only, so the second pass leaves the FIFO empty
            if (p == 0) begin
                rfm <= 1'b1;
                op(1, 4'h8, rnd());
                rfm <= 1'b0;
            end
        end
        rtm <= 1'b0;
        op(1, 4'h8, rnd());
        settle();
        flags();
        // Fill past full, watching the near-full boundary, then drain
        for (int i = 0; i < DEPTH + 2; i++) begin
            d = rnd();
            if (q.size() < DEPTH) begin
                q.push_back(d);
            end
            op(0, 4'h6, d);
            if (i == DEPTH - yo - 2 || i == DEPTH - yo - 1 || i == DEPTH + 1) begin
                settle();
                flags();
            end
        end
        while (q.size() > 0) begin
            op(1, 4'h4, rnd());
            chk(rd, q.pop_front());
            if (q.size() == xo + 1 || q.size() == xo) begin
                settle();
                flags();
            end
        end
        settle();
        flags();
        // Mid-run reset into the low preset offsets, with mail pending
        op(0, 4'h7, rnd());
        settle();
        RST_B <= 1'b0;
        repeat (12) @(posedge b_clk);
        @(posedge REF_CLK);
        RST_B <= 1'b1;
        xo = PRESET_LO;
        yo = PRESET_LO;
        settle();
        chkf(mb1_n, 1'b1);
        flags();
        for (int i = 0; i <= PRESET_LO; i++) begin
            d = rnd();
            q.push_back(d);
            op(0, 4'h6, d);
        end
        settle();
        flags();
        op(1, 4'h4, rnd());
        chk(rd, q.pop_front());
        settle();
        flags();
        give_verdict();
    end
endmodule
